//--- rtl/gpio_cn_pkg.sv
// constants and types for the gpio port with change notification
// assumes a single 100 MHz clock and a plain register access port
package gpio_cn_pkg;

  // ==========================================================
  // geometry
  localparam int PORT_W_DEF  = 16;
  localparam int NPORT_DEF   = 2;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // register selects on the access port
  typedef enum logic [3:0] {
    SEL_DIRECTION   = 4'h0,
    SEL_LATCH       = 4'h1,
    SEL_LEVEL       = 4'h2,
    SEL_OPEN_DRAIN  = 4'h3,
    SEL_ANALOG      = 4'h4,
    SEL_CN_CONTROL  = 4'h5,
    SEL_CN_EN_ZERO  = 4'h6,
    SEL_CN_EN_ONE   = 4'h7,
    SEL_CN_STATUS   = 4'h8
  } reg_sel_t;

  // access operation: base register or one of its aliases
  typedef enum logic [1:0] {
    OP_BASE = 2'h0,
    OP_CLR  = 2'h1,
    OP_SET  = 2'h2,
    OP_INV  = 2'h3
  } op_t;

  // ==========================================================
  // control field positions
  localparam int CN_ON_BIT    = 15;
  localparam int CN_STYLE_BIT = 11;

  // ==========================================================
  // reset values
  localparam logic [15:0] DIR_RST    = 16'hffff;
  localparam logic [15:0] ANALOG_RST = 16'hffff;
  localparam logic [15:0] ZERO_RST   = 16'h0000;

endpackage

//--- rtl/gpio_port_change_notify.sv
// gpio ports with aliases, merging, open drain, analog select and change notice
// assumes pins from outside the ref_clk domain and a same-clock access port
`timescale 1ns/1ps

module gpio_port_change_notify
  import gpio_cn_pkg::*;
#(
  parameter int PORT_W = PORT_W_DEF,
  parameter int NPORT  = NPORT_DEF
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst,
  input  wire logic                                 wr_en,
  input  wire logic [((NPORT > 1) ? $clog2(NPORT) : 1)-1:0] wr_port,
  input  wire reg_sel_t                             wr_sel,
  input  wire op_t                                  wr_op,
  input  wire logic [2*PORT_W-1:0]                  wr_data,
  input  wire logic                                 rd_en,
  input  wire logic [((NPORT > 1) ? $clog2(NPORT) : 1)-1:0] rd_port,
  input  wire reg_sel_t                             rd_sel,
  input  wire op_t                                  rd_op,
  output logic      [2*PORT_W-1:0]                  rd_data,
  output logic                                      rd_valid,
  input  wire logic [NPORT-1:0]                     port_merge_enable,
  input  wire logic [NPORT-1:0][PORT_W-1:0]         pin_in,
  output logic      [NPORT-1:0][PORT_W-1:0]         pin_out,
  output logic      [NPORT-1:0][PORT_W-1:0]         pin_oe_n,
  output logic      [NPORT-1:0]                     change_notice_irq
);

  localparam int PI_W = (NPORT > 1) ? $clog2(NPORT) : 1;

  // ==========================================================
  // state
  logic [NPORT-1:0][PORT_W-1:0] dir_r;
  logic [NPORT-1:0][PORT_W-1:0] lat_r;
  logic [NPORT-1:0][PORT_W-1:0] odc_r;
  logic [NPORT-1:0][PORT_W-1:0] ansel_r;
  logic [NPORT-1:0][PORT_W-1:0] cncon_r;
  logic [NPORT-1:0][PORT_W-1:0] cnen0_r;
  logic [NPORT-1:0][PORT_W-1:0] cnen1_r;
  logic [NPORT-1:0][PORT_W-1:0] cnstat_r;
  logic [NPORT-1:0][PORT_W-1:0] last_read_r;
  logic [NPORT-1:0][PORT_W-1:0] prev_r;
  logic [NPORT-1:0][PORT_W-1:0] sync1_r;
  logic [NPORT-1:0][PORT_W-1:0] sync2_r;
  logic [NPORT-1:0][PORT_W-1:0] sync3_r;
  logic [NPORT-1:0][PORT_W-1:0] wr_val;
  logic [NPORT-1:0]             wr_port_hit;
  logic [NPORT-1:0]             rd_port_hit;
  logic [NPORT-1:0][PORT_W-1:0] event_bits;
  logic [2*PORT_W-1:0]          rd_data_nxt;

  // ==========================================================
  // alias operation
  // alias bit ops
  function automatic logic [PORT_W-1:0] apply_op(input logic [PORT_W-1:0] base,
                                                 input logic [PORT_W-1:0] data,
                                                 input op_t op);
    logic [PORT_W-1:0] res;
    res = base;
    case (op)
      OP_BASE: res = data;
      OP_CLR:  res = base & ~data;
      OP_SET:  res = base | data;
      OP_INV:  res = base ^ data;
      default: res = base;
    endcase
    return res;
  endfunction

  // ==========================================================
  // port addressing, shared by write and read
  // merged upper half
  function automatic logic port_hit(input logic [PI_W-1:0] idx, input int q,
                                    input logic [NPORT-1:0] merge);
    logic hit;
    hit = (idx == PI_W'(q));
    if (q > 0) begin
      if (merge[q-1] && (idx == PI_W'(q-1))) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic upper_half(input logic [PI_W-1:0] idx, input int q);
    return (q > 0) && (idx == PI_W'(q-1));
  endfunction

  // ==========================================================
  // write select decode
  function automatic logic wr_to(input int q, input reg_sel_t sel);
    return wr_port_hit[q] && (wr_sel == sel);
  endfunction

  // ==========================================================
  // pin synchroniser
  // three stage sync
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      prev_r  <= sync3_r;
    end
  end

  // ==========================================================
  // per port write decode and change events
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      logic              on;
      logic              style;
      logic [PORT_W-1:0] rise;
      logic [PORT_W-1:0] fall;
      logic [PORT_W-1:0] mismatch;
      assign wr_port_hit[gp] = wr_en && port_hit(wr_port, gp, port_merge_enable);
      assign rd_port_hit[gp] = rd_en && port_hit(rd_port, gp, port_merge_enable);
      assign wr_val[gp]      = upper_half(wr_port, gp) ? wr_data[2*PORT_W-1:PORT_W]
                                                       : wr_data[PORT_W-1:0];
      assign on              = cncon_r[gp][CN_ON_BIT];
      assign style           = cncon_r[gp][CN_STYLE_BIT];
      // edge and mismatch terms
      assign rise            = sync3_r[gp] & ~prev_r[gp];
      assign fall            = ~sync3_r[gp] & prev_r[gp];
      assign mismatch        = sync3_r[gp] ^ last_read_r[gp];
      assign event_bits[gp] = !on ? '0 :
        (!style ? (cnen0_r[gp] & mismatch)
                : ((cnen0_r[gp] & rise) |
                   (cnen1_r[gp] & fall)));
      assign change_notice_irq[gp] = on && (|cnstat_r[gp]);
      assign pin_out[gp]  = lat_r[gp] & ~odc_r[gp];
      assign pin_oe_n[gp] = dir_r[gp] | (odc_r[gp] & lat_r[gp]);
    end
  endgenerate

  // ==========================================================
  // configuration registers
  // inputs after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_r <= {NPORT{DIR_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (wr_to(q, SEL_DIRECTION)) begin
          dir_r[q] <= apply_op(dir_r[q], wr_val[q], wr_op);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lat_r <= {NPORT{ZERO_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (wr_to(q, SEL_LATCH) || wr_to(q, SEL_LEVEL)) begin
          lat_r[q] <= apply_op(lat_r[q], wr_val[q], wr_op);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      odc_r <= {NPORT{ZERO_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (wr_to(q, SEL_OPEN_DRAIN)) begin
          odc_r[q] <= apply_op(odc_r[q], wr_val[q], wr_op);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ansel_r <= {NPORT{ANALOG_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (wr_to(q, SEL_ANALOG)) begin
          ansel_r[q] <= apply_op(ansel_r[q], wr_val[q], wr_op);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cncon_r <= {NPORT{ZERO_RST}};
      cnen0_r <= {NPORT{ZERO_RST}};
      cnen1_r <= {NPORT{ZERO_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (wr_to(q, SEL_CN_CONTROL)) begin
          cncon_r[q] <= apply_op(cncon_r[q], wr_val[q], wr_op);
        end
        if (wr_to(q, SEL_CN_EN_ZERO)) begin
          cnen0_r[q] <= apply_op(cnen0_r[q], wr_val[q], wr_op);
        end
        if (wr_to(q, SEL_CN_EN_ONE)) begin
          cnen1_r[q] <= apply_op(cnen1_r[q], wr_val[q], wr_op);
        end
      end
    end
  end

  // ==========================================================
  // change status flags
  // sticky flag, set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnstat_r <= {NPORT{ZERO_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (wr_to(q, SEL_CN_STATUS)) begin
          cnstat_r[q] <= apply_op(cnstat_r[q], wr_val[q], wr_op) | event_bits[q];
        end else begin
          cnstat_r[q] <= cnstat_r[q] | event_bits[q];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_read_r <= {NPORT{ZERO_RST}};
    end else begin
      for (int q = 0; q < NPORT; q++) begin
        if (rd_port_hit[q] && rd_sel == SEL_LEVEL && rd_op == OP_BASE) begin
          last_read_r[q] <= sync3_r[q];
        end
      end
    end
  end

  // ==========================================================
  // read path
  function automatic logic [PORT_W-1:0] reg_value(input int q, input reg_sel_t sel);
    logic [PORT_W-1:0] v;
    v = '0;
    if (sel == SEL_DIRECTION) begin
      v = dir_r[q];
    end else if (sel == SEL_LATCH) begin
      v = lat_r[q];
    end else if (sel == SEL_LEVEL) begin
      v = sync3_r[q] & ~ansel_r[q];
    end else if (sel == SEL_OPEN_DRAIN) begin
      v = odc_r[q];
    end else if (sel == SEL_ANALOG) begin
      v = ansel_r[q];
    end else if (sel == SEL_CN_CONTROL) begin
      v = cncon_r[q];
    end else if (sel == SEL_CN_EN_ZERO) begin
      v = cnen0_r[q];
    end else if (sel == SEL_CN_EN_ONE) begin
      v = cnen1_r[q];
    end else if (sel == SEL_CN_STATUS) begin
      v = cnstat_r[q];
    end
    return v;
  endfunction

  always_comb begin
    rd_data_nxt = '0;
    for (int q = 0; q < NPORT; q++) begin
      if (rd_port == PI_W'(q)) begin
        rd_data_nxt[PORT_W-1:0] = reg_value(q, rd_sel);
        if ((q + 1 < NPORT) && port_merge_enable[q]) begin
          rd_data_nxt[2*PORT_W-1:PORT_W] = reg_value(q + 1, rd_sel);
        end
      end
    end
    if (rd_op != OP_BASE) begin
      rd_data_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_data_nxt;
      end
    end
  end

endmodule

//--- test/gpio_pcn_chk.sv
// checker for the gpio port block, bound to its top module
// assumes one clock ref_clk and synchronous active-high rst
`timescale 1ns/1ps

module gpio_pcn_chk
  import gpio_cn_pkg::*;
#(
  parameter int PORT_W = 16,
  parameter int NPORT  = 2
) (
  input  wire logic                                         ref_clk,
  input  wire logic                                         rst,
  input  wire logic                                         wr_en,
  input  wire logic                                         rd_en,
  input  wire logic [((NPORT > 1) ? $clog2(NPORT) : 1)-1:0] rd_port,
  input  wire op_t                                          rd_op,
  input  wire logic [2*PORT_W-1:0]                          rd_data,
  input  wire logic                                         rd_valid,
  input  wire logic [NPORT-1:0]                             port_merge_enable,
  input  wire logic [NPORT-1:0][PORT_W-1:0]                 pin_out,
  input  wire logic [NPORT-1:0][PORT_W-1:0]                 pin_oe_n,
  input  wire logic [NPORT-1:0]                             change_notice_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // read port
  // read answer
  AST_RD_VALID: assert property (rd_en |=> rd_valid) else $error("rd_valid missing");
  AST_RD_IDLE: assert property (!rd_en |=> !rd_valid) else $error("rd_valid without read");
  AST_RD_HOLD: assert property (!rd_en |=> $stable(rd_data)) else $error("rd_data moved");
  AST_ALIAS_ZERO: assert property (rd_en && rd_op != OP_BASE |=> rd_data == '0) else $error("alias read nonzero");
  AST_UPPER_ZERO: assert property (
    rd_en && rd_op == OP_BASE && (rd_port == NPORT - 1 || !port_merge_enable[rd_port])
    |=> rd_data[2*PORT_W-1:PORT_W] == '0) else $error("upper half nonzero");
  // ==========================================================
  // pins and request
  // all inputs
  AST_RESET_STATE: assert property ($fell(rst) |-> (&pin_oe_n) && !(|change_notice_irq)) else $error("reset state");
  AST_PINS_HOLD: assert property (!wr_en |=> $stable(pin_out) && $stable(pin_oe_n)) else $error("pins moved");
  AST_IRQ_STICKY: assert property (
    !wr_en |=> (change_notice_irq & $past(change_notice_irq)) == $past(change_notice_irq))
    else $error("request dropped");
  COV_MERGED_RD: cover property (rd_en && port_merge_enable[0] && rd_port == 0);
  COV_IRQ: cover property ($rose(change_notice_irq[NPORT-1]));
  COV_DRIVE: cover property (!(&pin_oe_n));
endmodule

bind gpio_port_change_notify gpio_pcn_chk #(.PORT_W(PORT_W), .NPORT(NPORT)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .rd_port(rd_port), .rd_op(rd_op),
  .rd_data(rd_data), .rd_valid(rd_valid), .port_merge_enable(port_merge_enable), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .change_notice_irq(change_notice_irq)
);

//--- test/pin_partner.sv
// external pin model for two ports
// assumes released pins settle at the external level given by the bench
`timescale 1ns/1ps

module pin_partner (
  input  wire logic [1:0][15:0] pin_out,
  input  wire logic [1:0][15:0] pin_oe_n,
  input  wire logic [1:0][15:0] ext,
  output logic      [1:0][15:0] pin_in
);
  // ==========================================================
  // wire level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule

//--- test/gpio_port_change_notify_tb_top.sv
// testbench for the gpio port block with change notice
// assumes pin_partner on the pins and the bound checker
`timescale 1ns/1ps

module gpio_port_change_notify_tb_top;
  import gpio_cn_pkg::*;
  typedef struct {reg_sel_t s; op_t o; logic [15:0] d; reg_sel_t r; logic [15:0] e;} row_t;
  logic             ref_clk = 1'h0;
  logic             rst     = 1'h1;
  logic             wr_en   = 1'h0;
  logic             rd_en   = 1'h0;
  logic [0:0]       wr_port = 1'h0;
  logic [0:0]       rd_port = 1'h0;
  reg_sel_t         wr_sel  = SEL_DIRECTION;
  reg_sel_t         rd_sel  = SEL_DIRECTION;
  op_t              wr_op   = OP_BASE;
  op_t              rd_op   = OP_BASE;
  logic [31:0]      wr_data = 32'h0;
  logic [1:0]       merge   = 2'h0;
  logic [1:0][15:0] ext     = 32'hffffffff;
  logic [31:0]      rd_data;
  logic             rd_valid;
  logic [1:0][15:0] pin_in, pin_out, pin_oe_n;
  logic [1:0]       irq;
  int               n_fail = 0;
  int               comparisons = 0;
  row_t rows [8] = '{'{SEL_ANALOG, OP_CLR, 16'h00ff, SEL_ANALOG, 16'hff00},
    '{SEL_ANALOG, OP_SET, 16'h0f0f, SEL_ANALOG, 16'hff0f}, '{SEL_ANALOG, OP_INV, 16'hffff, SEL_ANALOG, 16'h00f0},
    '{SEL_ANALOG, OP_BASE, 16'h0000, SEL_ANALOG, 16'h0000}, '{SEL_LATCH, OP_BASE, 16'ha5c3, SEL_LATCH, 16'ha5c3},
    '{SEL_LEVEL, OP_BASE, 16'h5a5a, SEL_LATCH, 16'h5a5a}, '{SEL_DIRECTION, OP_CLR, 16'hffff, SEL_DIRECTION, 16'h0000},
    '{SEL_OPEN_DRAIN, OP_SET, 16'h00ff, SEL_OPEN_DRAIN, 16'h00ff}};

  gpio_port_change_notify DUT (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en), .wr_port(wr_port), .wr_sel(wr_sel),
    .wr_op(wr_op), .wr_data(wr_data), .rd_en(rd_en), .rd_port(rd_port), .rd_sel(rd_sel), .rd_op(rd_op),
    .rd_data(rd_data), .rd_valid(rd_valid), .port_merge_enable(merge), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .change_notice_irq(irq));
  pin_partner u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));

  always #5 ref_clk = ~ref_clk;

  // ==========================================================
  // shared tasks
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [0:0] p, input reg_sel_t s, input op_t o, input logic [31:0] d);
    @(negedge ref_clk);
    wr_port = p;
    wr_sel = s;
    wr_op = o;
    wr_data = d;
    wr_en = 1'h1;
    @(negedge ref_clk);
    wr_en = 1'h0;
  endtask
  task rdc(input logic [0:0] p, input reg_sel_t s, input op_t o, input logic [31:0] e);
    @(negedge ref_clk);
    rd_port = p;
    rd_sel = s;
    rd_op = o;
    rd_en = 1'h1;
    @(negedge ref_clk);
    rd_en = 1'h0;
    chk("rd_valid", {31'h0, rd_valid}, 32'h1);
    chk("rd_data", rd_data, e);
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'h0;
    chk("pin_oe_n", pin_oe_n, 32'hffffffff);
    rdc(1'h0, SEL_DIRECTION, OP_BASE, 32'hffff);
    rdc(1'h1, SEL_ANALOG, OP_BASE, 32'hffff);
    rdc(1'h0, SEL_DIRECTION, OP_SET, 32'h0);
    $display("end reset");
    foreach (rows[i]) begin
      wr(1'h0, rows[i].s, rows[i].o, {16'h0, rows[i].d});
      rdc(1'h0, rows[i].r, OP_BASE, {16'h0, rows[i].e});
    end
    chk("pin_out", pin_out[0], 32'h5a00);
    chk("pin_oe_n", pin_oe_n[0], 32'h005a);
    ext[0] = 16'h0000;
    repeat (4) @(negedge ref_clk);
    rdc(1'h0, SEL_LEVEL, OP_BASE, 32'h5a00);
    wr(1'h0, SEL_ANALOG, OP_SET, 32'h0f00);
    rdc(1'h0, SEL_LEVEL, OP_BASE, 32'h5000);
    chk("pin_out", pin_out[0], 32'h5a00);
    $display("end table and pins");
    wr(1'h1, SEL_ANALOG, OP_BASE, 32'h0);
    ext[1] = 16'h0000;
    repeat (5) @(negedge ref_clk);
    ext[1] = 16'h0001;
    @(negedge ref_clk);
    rdc(1'h1, SEL_LEVEL, OP_BASE, 32'h0000);
    ext[1] = 16'h0003;
    repeat (2) @(negedge ref_clk);
    rdc(1'h1, SEL_LEVEL, OP_BASE, 32'h0003);
    $display("end sync");
    ext[1] = 16'h0000;
    wr(1'h1, SEL_CN_CONTROL, OP_BASE, 32'h8800);
    wr(1'h1, SEL_CN_EN_ZERO, OP_BASE, 32'h0001);
    wr(1'h1, SEL_CN_STATUS, OP_CLR, 32'hffff);
    ext[1] = 16'h0001;
    repeat (8) @(negedge ref_clk);
    chk("irq", {30'h0, irq}, 32'h2);
    rdc(1'h1, SEL_CN_STATUS, OP_BASE, 32'h0001);
    wr(1'h1, SEL_CN_STATUS, OP_CLR, 32'h0001);
    ext[1] = 16'h0000;
    repeat (8) @(negedge ref_clk);
    chk("irq", {30'h0, irq}, 32'h0);
    wr(1'h1, SEL_CN_CONTROL, OP_BASE, 32'h8000);
    rdc(1'h1, SEL_LEVEL, OP_BASE, 32'h0000);
    wr(1'h1, SEL_CN_STATUS, OP_CLR, 32'hffff);
    ext[1] = 16'h0001;
    repeat (8) @(negedge ref_clk);
    chk("irq", {30'h0, irq}, 32'h2);
    wr(1'h1, SEL_CN_CONTROL, OP_BASE, 32'h0000);
    repeat (2) @(negedge ref_clk);
    chk("irq", {30'h0, irq}, 32'h0);
    $display("end notice");
    merge = 2'h1;
    wr(1'h0, SEL_LATCH, OP_BASE, 32'hbeef1234);
    rdc(1'h1, SEL_LATCH, OP_BASE, 32'hbeef);
    rdc(1'h0, SEL_LATCH, OP_BASE, 32'hbeef1234);
    merge = 2'h2;
    rdc(1'h1, SEL_LATCH, OP_BASE, 32'hbeef);
    $display("end merge");
    finish_test();
  end
endmodule
